//--- rmc_pkg.sv
// Package for the regulator mode control block: map, fields, timing.
`default_nettype none
package rmc_pkg;
  // Register word indexes on the bus
  localparam logic [3:0] RMC_ADDR_PROTECT = 4'h0;
  localparam logic [3:0] RMC_ADDR_CONTROL = 4'h1;
  localparam logic [3:0] RMC_ADDR_TIMING = 4'h2;
  localparam logic [3:0] RMC_ADDR_FLAG = 4'h3;
  localparam logic [3:0] RMC_ADDR_IRQ_EN = 4'h4;
  localparam logic [3:0] RMC_ADDR_FLAG_CLR = 4'h5;
  localparam logic [3:0] RMC_ADDR_CLOCKS = 4'h6;
  // Key that opens the protected registers
  localparam logic [15:0] RMC_PROTECT_KEY = 16'h0096;
  // Mode field encodings
  localparam logic [2:0] RMC_MODE_AUTO = 3'h0;
  localparam logic [2:0] RMC_MODE_NORMAL = 3'h2;
  localparam logic [2:0] RMC_MODE_ECONOMY = 3'h3;
  localparam logic [2:0] RMC_MODE_SUPER = 3'h5;
  localparam logic [2:0] RMC_MODE_RESET = RMC_MODE_AUTO;
  localparam logic [1:0] RMC_PUMP_DIV_RESET = 2'h0;
  // Field positions
  localparam int RMC_FLAG_COMPLETE_BIT = 0;
  localparam int RMC_CLK_PUMP_BIT = 1;
  // Delays in microseconds, counted on slow crystal ticks
  localparam int RMC_SLOW_HZ = 32768;
  localparam int RMC_ECO_DELAY_US = 1000;
  localparam int RMC_SUPER_EXIT_US = 10000;
  // Least time rounds up to whole slow ticks
  localparam int RMC_ECO_TICKS = (RMC_ECO_DELAY_US * RMC_SLOW_HZ + 999999) / 1000000;
  localparam int RMC_SUPER_TICKS = (RMC_SUPER_EXIT_US * RMC_SLOW_HZ + 999999) / 1000000;
  localparam int RMC_TICK_W = 10;
  // Regulator state actually applied
  typedef enum logic [1:0] {
    RMC_REG_NORMAL,
    RMC_REG_ECONOMY,
    RMC_REG_SUPER
  } rmc_reg_t;
  // Oscillator and CPU status bundle
  typedef struct packed {
    logic fast_running;
    logic slow_running;
    logic sleep_entry;
    logic wake;
  } rmc_clk_t;
endpackage
`default_nettype wire

//--- rmc_top.sv
// Regulator mode control: key lock, mode select, automatic switching, flags.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
`default_nettype none
// Notes on behaviour
// - Key 0x0096 unlocks; other values lock
// - Mode 0x2 normal, 0x3 economy
// - Mode 0x0 automatic, 0x5 super economy
// - Auto: fast clocks stop, economy 1 ms
// - Auto: fast clock start, normal at once
// - Auto: sleep all stopped, economy, no flag
// - Auto: sleep slow only, economy 1 ms
// - Fast clock at sleep blocks economy
// - Wake: normal if a fast clock runs, else economy
// - Leaving super economy for auto or economy, flag after 10 ms
// - Super economy pump clocked by slow crystal
module rmc_top
  import rmc_pkg::*;
#(
  parameter int ECO_TICKS = RMC_ECO_TICKS,
  parameter int SUPER_TICKS = RMC_SUPER_TICKS
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic slow_clk_pin,
  input wire rmc_clk_t clk_status,
  output logic economy_on,
  output logic pump_on,
  output logic pump_clk_en,
  output logic irq
);
  // Slow crystal pin synchroniser and rising edge tick
  logic slow_s1_q, slow_s2_q, slow_s3_q;
  always_ff @(posedge clk)
  begin
    slow_s1_q <= slow_clk_pin;
    slow_s2_q <= slow_s1_q;
    slow_s3_q <= slow_s2_q;
  end
  wire slow_tick = slow_s2_q & ~slow_s3_q;

  // Bus: one wait cycle on every access so read data comes from a flop
  logic ack_q;
  wire access = avs_read | avs_write;
  assign avs_waitrequest = access & ~ack_q;
  wire wr_go = avs_write & ack_q;
  always_ff @(posedge clk)
  begin
    if (rst)
      ack_q <= 1'b0;
    else
      ack_q <= access & ~ack_q;
  end

  // Register decode
  wire wr_protect = wr_go && avs_address == RMC_ADDR_PROTECT;
  wire wr_control = wr_go && avs_address == RMC_ADDR_CONTROL;
  wire wr_timing = wr_go && avs_address == RMC_ADDR_TIMING;
  wire wr_irq_en = wr_go && avs_address == RMC_ADDR_IRQ_EN;
  wire wr_flag_clr = wr_go && avs_address == RMC_ADDR_FLAG_CLR;

  // Protection key register
  logic [15:0] key_q;
  logic unlocked_q;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      key_q <= 16'h0000;
      unlocked_q <= 1'b0;
    end
    else if (wr_protect)
    begin
      key_q <= avs_writedata[15:0];
      unlocked_q <= avs_writedata[15:0] == RMC_PROTECT_KEY;
    end
  end

  // Mode and pump divider, held while locked
  logic [2:0] mode_q;
  logic [1:0] pump_div_q;
  logic irq_en_q;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mode_q <= RMC_MODE_RESET;
      pump_div_q <= RMC_PUMP_DIV_RESET;
      irq_en_q <= 1'b0;
    end
    else
    begin
      if (wr_control && unlocked_q)
        mode_q <= avs_writedata[2:0];
      if (wr_timing && unlocked_q)
        pump_div_q <= avs_writedata[1:0];
      if (wr_irq_en)
        irq_en_q <= avs_writedata[RMC_FLAG_COMPLETE_BIT];
    end
  end

  wire sel_normal = mode_q == RMC_MODE_NORMAL;
  wire sel_economy = mode_q == RMC_MODE_ECONOMY;
  wire sel_auto = mode_q == RMC_MODE_AUTO;
  wire sel_super = mode_q == RMC_MODE_SUPER;

  // Status inputs come from other domains
  logic [3:0] st_s1_q, st_s2_q;
  always_ff @(posedge clk)
  begin
    st_s1_q <= clk_status;
    st_s2_q <= st_s1_q;
  end
  rmc_clk_t st;
  assign st = st_s2_q;
  logic fast_prev_q, sleep_prev_q, wake_prev_q, asleep_q;
  wire fast_start = st.fast_running & ~fast_prev_q;
  wire sleep_rise = st.sleep_entry & ~sleep_prev_q;
  wire wake_rise = st.wake & ~wake_prev_q;

  // Applied regulator state and timers
  rmc_reg_t reg_q, reg_d;
  logic [RMC_TICK_W-1:0] eco_cnt_q;
  logic [RMC_TICK_W+1:0] sup_cnt_q;
  logic sup_exit_q, was_super_q, flag_q;
  // Economy wait: normal, auto, fast clocks stopped, not a full-stop sleep
  wire eco_wait = sel_auto && reg_q == RMC_REG_NORMAL && !st.fast_running
                  && (st.slow_running || !asleep_q);
  wire eco_done = eco_wait && slow_tick
                  && eco_cnt_q == RMC_TICK_W'(ECO_TICKS - 1);
  wire sup_done = sup_exit_q && slow_tick
                  && sup_cnt_q == (RMC_TICK_W + 2)'(SUPER_TICKS - 1);
  // sleep with fast clock stays normal
  wire sleep_all_off = sleep_rise && !st.fast_running && !st.slow_running;

  // Next applied regulator state
  always_comb
  begin
    reg_d = reg_q;
    if (sel_super)
      reg_d = RMC_REG_SUPER;
    else if (sel_normal)
      reg_d = RMC_REG_NORMAL;
    else if (sel_economy)
      reg_d = RMC_REG_ECONOMY;
    else if (wake_rise)
      reg_d = st.fast_running ? RMC_REG_NORMAL : RMC_REG_ECONOMY;
    else if (st.fast_running)
      reg_d = RMC_REG_NORMAL;
    else if (reg_q == RMC_REG_SUPER)
      reg_d = RMC_REG_ECONOMY;
    else if (sel_auto && reg_q == RMC_REG_NORMAL && sleep_all_off)
      reg_d = RMC_REG_ECONOMY;
    else if (eco_done)
      reg_d = RMC_REG_ECONOMY;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      reg_q <= RMC_REG_NORMAL;
      fast_prev_q <= 1'b0;
      sleep_prev_q <= 1'b0;
      wake_prev_q <= 1'b0;
      asleep_q <= 1'b0;
    end
    else
    begin
      reg_q <= reg_d;
      fast_prev_q <= st.fast_running;
      sleep_prev_q <= st.sleep_entry;
      wake_prev_q <= st.wake;
      asleep_q <= sleep_rise ? 1'b1 : (wake_rise ? 1'b0 : asleep_q);
    end
  end

  // 1 ms timer on slow ticks
  always_ff @(posedge clk)
  begin
    if (rst)
      eco_cnt_q <= '0;
    else if (!eco_wait)
      eco_cnt_q <= '0;
    else if (slow_tick)
      eco_cnt_q <= eco_cnt_q + RMC_TICK_W'(1);
  end

  // 10 ms timer after leaving super economy
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sup_cnt_q <= '0;
      sup_exit_q <= 1'b0;
      was_super_q <= 1'b0;
    end
    else
    begin
      was_super_q <= sel_super;
      // start on exit to auto or economy
      if (was_super_q && (sel_auto || sel_economy))
      begin
        sup_exit_q <= 1'b1;
        sup_cnt_q <= '0;
      end
      else if (sup_exit_q && !(sel_auto || sel_economy))
      begin
        sup_exit_q <= 1'b0;
        sup_cnt_q <= '0;
      end
      else if (sup_done)
        sup_exit_q <= 1'b0;
      else if (sup_exit_q && slow_tick)
        sup_cnt_q <= sup_cnt_q + (RMC_TICK_W + 2)'(1);
    end
  end

  // Completion flag: set wins over clear
  wire flag_set = eco_done || sup_done;
  always_ff @(posedge clk)
  begin
    if (rst)
      flag_q <= 1'b0;
    else if (flag_set)
      flag_q <= 1'b1;
    else if (wr_flag_clr && avs_writedata[RMC_FLAG_COMPLETE_BIT])
      flag_q <= 1'b0;
  end
  assign irq = flag_q & irq_en_q;

  // Read mux, registered
  always_ff @(posedge clk)
  begin
    if (rst)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read && !ack_q)
      unique case (avs_address)
        RMC_ADDR_PROTECT: avs_readdata <= {31'h0000_0000, unlocked_q};
        RMC_ADDR_CONTROL: avs_readdata <= {29'h0000_0000, mode_q};
        RMC_ADDR_TIMING: avs_readdata <= {30'h0000_0000, pump_div_q};
        RMC_ADDR_FLAG: avs_readdata <= {31'h0000_0000, flag_q};
        RMC_ADDR_IRQ_EN: avs_readdata <= {31'h0000_0000, irq_en_q};
        RMC_ADDR_CLOCKS: avs_readdata <= {30'h0000_0000, reg_q};
        default: avs_readdata <= 32'h0000_0000;
      endcase
  end

  // pump steps on slow crystal ticks
  logic [3:0] pump_cnt_q;
  always_ff @(posedge clk)
  begin
    if (rst)
      pump_cnt_q <= 4'h0;
    else if (slow_tick)
      pump_cnt_q <= pump_cnt_q + 4'h1;
  end
  // Divider 0..3 picks ratio 1,2,4,8 of the slow tick
  wire [3:0] div_mask = (4'h1 << pump_div_q) - 4'h1;
  assign pump_clk_en = reg_q == RMC_REG_SUPER && slow_tick
                       && (pump_cnt_q & div_mask) == 4'h0;
  assign pump_on = reg_q == RMC_REG_SUPER;
  assign economy_on = reg_q == RMC_REG_ECONOMY;

  // Checks
  a_lock_key: assert property (@(posedge clk) disable iff (rst)
    wr_protect |=> unlocked_q == ($past(avs_writedata[15:0]) == 16'h0096))
    else $error("lock state wrong after key write");
  a_lock_hold: assert property (@(posedge clk) disable iff (rst)
    (wr_control && !unlocked_q) |=> $stable(mode_q))
    else $error("mode changed while locked");
  a_mode_normal: assert property (@(posedge clk) disable iff (rst)
    mode_q == 3'h2 |=> reg_q == RMC_REG_NORMAL)
    else $error("normal select not applied");
  a_mode_super: assert property (@(posedge clk) disable iff (rst)
    mode_q == 3'h5 |=> pump_on)
    else $error("super economy not applied");
  a_fast_normal: assert property (@(posedge clk) disable iff (rst)
    (sel_auto && st.fast_running && !wake_rise) |=> reg_q == RMC_REG_NORMAL)
    else $error("fast clock did not force normal");
  a_sleep_eco: assert property (@(posedge clk) disable iff (rst)
    (sel_auto && reg_q == RMC_REG_NORMAL && sleep_all_off && !wake_rise)
    |=> economy_on && !$rose(flag_q))
    else $error("full-stop sleep did not give economy");
  a_eco_flag: assert property (@(posedge clk) disable iff (rst)
    eco_done |=> economy_on && flag_q)
    else $error("timed economy without flag");
  // Sleep entered while a fast source still runs
  sequence s_sleep_busy;
    sel_auto && sleep_rise && st.fast_running && !wake_rise;
  endsequence
  a_sleep_block: assert property (@(posedge clk) disable iff (rst)
    s_sleep_busy |=> !economy_on)
    else $error("economy entered with fast clock");
  // Start event of a fast source in automatic mode
  sequence s_fast_start;
    sel_auto && fast_start;
  endsequence
  a_start_normal: assert property (@(posedge clk) disable iff (rst)
    s_fast_start |=> !economy_on && !pump_on)
    else $error("clock start left economy on");
  a_super_flag: assert property (@(posedge clk) disable iff (rst)
    sup_done |=> flag_q)
    else $error("super exit flag missing");
  a_eco_restart: assert property (@(posedge clk) disable iff (rst)
    !eco_wait |=> eco_cnt_q == '0)
    else $error("economy timer not restarted");
  a_wake_pick: assert property (@(posedge clk) disable iff (rst)
    (sel_auto && wake_rise && !st.fast_running) |=> economy_on)
    else $error("wake did not choose economy");
  a_pump_tick: assert property (@(posedge clk) disable iff (rst)
    pump_clk_en |-> slow_tick && pump_on)
    else $error("pump clock not from slow crystal");
  a_timed_sleep: assert property (@(posedge clk) disable iff (rst)
    (eco_wait && asleep_q && slow_tick && eco_cnt_q == RMC_TICK_W'(ECO_TICKS - 1))
    |=> flag_q)
    else $error("sleep timed economy without flag");
endmodule
`default_nettype wire

//--- rmc_tb.sv
// Self-checking bench for the regulator mode control block.
`default_nettype none
module testbench
  import rmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, avs_read, avs_write, slow_clk_pin;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q, r;
  logic avs_waitrequest, economy_on, pump_on, pump_clk_en, irq;
  rmc_clk_t clk_status;
  int n_mismatch, n_tests, seed, p0;
  int n_pump = 0;
  logic [2:0] ml [3] = '{RMC_MODE_NORMAL, RMC_MODE_ECONOMY, RMC_MODE_SUPER};

  // Short delays keep the run brief: 2 ticks economy, 3 ticks super exit
  rmc_top #(.ECO_TICKS(2), .SUPER_TICKS(3)) dut (.clk(clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .slow_clk_pin(slow_clk_pin),
    .clk_status(clk_status), .economy_on(economy_on), .pump_on(pump_on),
    .pump_clk_en(pump_clk_en), .irq(irq));

  // 40 MHz system clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Pump step counter
  always @(posedge clk) if (pump_clk_en === 1'b1) n_pump <= n_pump + 1;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // One Avalon transfer; held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    // Answer and read data are taken at the rising edge
    do @(posedge clk); while (avs_waitrequest !== 1'b0 && ++k < 40);
    if (k >= 40) chk(1, 0, "bus hang");
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // New oscillator status, then time for the synchronisers
  task automatic st(input logic [3:0] s);
    @(posedge clk);
    clk_status <= s;
    repeat (6) @(posedge clk);
  endtask

  // Slow crystal ticks; the pin stands still between calls
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clk);
      slow_clk_pin <= 1'b1;
      repeat (8) @(posedge clk);
      slow_clk_pin <= 1'b0;
      repeat (8) @(posedge clk);
    end
    repeat (3) @(posedge clk);
  endtask

  function automatic logic [31:0] mode_state(input logic [2:0] m);
    return (m == RMC_MODE_ECONOMY) ? 32'h0000_0001 : (m == RMC_MODE_SUPER) ? 32'h0000_0002 : 0;
  endfunction

  task automatic results();
    if (n_mismatch == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog well beyond the expected six hundred or so cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    chk(1, 0, "watchdog");
    results();
  end

  initial
  begin
    seed = 32'h47f5;
    n_mismatch = 0;
    n_tests = 0;
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0000_0000;
    slow_clk_pin = 1'b0;
    clk_status = 4'b1100;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // Reset values, enable included, clear register skipped
    for (int a = 0; a < 7; a++)
      if (a != 5)
      begin
        bus(0, a[3:0], 0);
        chk(q, 0, "reset value");
      end
    chk(irq, 0, "irq at reset");
    bus(1, RMC_ADDR_CONTROL, 32'h0000_0005);
    bus(0, RMC_ADDR_CONTROL, 0);
    chk(q, 0, "locked mode write");
    bus(1, RMC_ADDR_TIMING, 32'h0000_0003);
    bus(0, RMC_ADDR_TIMING, 0);
    chk(q, 0, "locked divider write");
    // Random keys and divider values
    repeat (4)
    begin
      r = $random(seed);
      if (r[15:0] == RMC_PROTECT_KEY) r = 32'h0000_0097;
      bus(1, RMC_ADDR_PROTECT, {16'h0000, RMC_PROTECT_KEY});
      bus(0, RMC_ADDR_PROTECT, 0);
      chk(q[0], 1, "unlock");
      bus(1, RMC_ADDR_TIMING, r);
      bus(0, RMC_ADDR_TIMING, 0);
      chk(q & 32'h0000_0003, r & 32'h0000_0003, "divider");
      bus(1, RMC_ADDR_PROTECT, r);
      bus(0, RMC_ADDR_PROTECT, 0);
      chk(q[0], 0, "relock");
      bus(1, RMC_ADDR_CONTROL, {29'h0, RMC_MODE_NORMAL});
      bus(0, RMC_ADDR_CONTROL, 0);
      chk(q, 0, "relocked write");
    end
    bus(1, 4'h9, r);
    bus(0, 4'h9, 0);
    chk(q, 0, "unmapped read");
    bus(1, RMC_ADDR_PROTECT, {16'h0000, RMC_PROTECT_KEY});
    bus(1, RMC_ADDR_TIMING, 32'h0000_0001);
    // Fast sources stopped before economy and super modes
    // fast sources stopped first
    st(4'b0100);
    for (int i = 0; i < 3; i++)
    begin
      bus(1, RMC_ADDR_CONTROL, {29'h0, ml[i]});
      bus(0, RMC_ADDR_CONTROL, 0);
      chk(q, {29'h0, ml[i]}, "mode field");
      bus(0, RMC_ADDR_CLOCKS, 0);
      chk(q, mode_state(ml[i]), "regulator state");
      chk(economy_on, ml[i] == RMC_MODE_ECONOMY, "economy out");
      chk(pump_on, ml[i] == RMC_MODE_SUPER, "pump out");
    end
    st(4'b0110);
    p0 = n_pump;
    // Divider 1 halves the slow ticks
    tick(4);
    chk(n_pump - p0, 2, "pump steps");
    chk(pump_on, 1, "pump in sleep");
    st(4'b0101);
    st(4'b0100);
    bus(1, RMC_ADDR_CONTROL, {29'h0, RMC_MODE_AUTO});
    tick(2);
    bus(0, RMC_ADDR_FLAG, 0);
    chk(q, 0, "super exit early");
    tick(1);
    bus(0, RMC_ADDR_FLAG, 0);
    chk(q, 1, "super exit flag");
    // Interrupt raised, masked and cleared
    bus(1, RMC_ADDR_IRQ_EN, 1);
    repeat (3) @(negedge clk);
    chk(irq, 1, "irq raised");
    bus(1, RMC_ADDR_IRQ_EN, 0);
    repeat (3) @(negedge clk);
    chk(irq, 0, "irq masked");
    bus(1, RMC_ADDR_IRQ_EN, 1);
    bus(1, RMC_ADDR_FLAG_CLR, 1);
    bus(0, RMC_ADDR_FLAG, 0);
    chk(q, 0, "flag cleared");
    chk(irq, 0, "irq cleared");
    st(4'b1100);
    chk(economy_on, 0, "fast start");
    // Withdrawn stop restarts the timer
    st(4'b0100);
    tick(1);
    st(4'b1100);
    st(4'b0100);
    tick(1);
    chk(economy_on, 0, "timer restart");
    tick(1);
    chk(economy_on, 1, "stop to economy");
    bus(0, RMC_ADDR_FLAG, 0);
    chk(q, 1, "stop flag");
    chk(irq, 1, "irq from flag");
    st(4'b1100);
    st(4'b1110);
    tick(3);
    chk(economy_on, 0, "sleep with fast");
    st(4'b0101);
    chk(economy_on, 1, "wake slow only");
    st(4'b1100);
    bus(1, RMC_ADDR_FLAG_CLR, 1);
    st(4'b0110);
    tick(1);
    chk(economy_on, 0, "slow sleep early");
    tick(1);
    chk(economy_on, 1, "slow sleep");
    bus(0, RMC_ADDR_FLAG, 0);
    chk(q, 1, "slow sleep flag");
    st(4'b1100);
    bus(1, RMC_ADDR_FLAG_CLR, 1);
    st(4'b0010);
    chk(economy_on, 1, "full stop sleep");
    bus(0, RMC_ADDR_FLAG, 0);
    chk(q, 0, "full stop no flag");
    bus(1, RMC_ADDR_PROTECT, 0);
    results();
  end
endmodule
`default_nettype wire
